// ===== inc/dic_regs.vh
// Constants for the digital input conditioning block: object indices,
// subindices, reset values and field positions.
// Assumes inclusion by bare name from the design file.
`ifndef DIC_REGS_VH
`define DIC_REGS_VH

// Object indices of the two configuration objects.
`define DIC_IDX_PIN_SETUP        16'h3231
`define DIC_IDX_INPUT_CTRL       16'h3240

// Subindices of the multipurpose pin setup object.
`define DIC_SUB_PIN_COUNT        8'h00
`define DIC_SUB_PIN_DIR          8'h01
`define DIC_SUB_PIN_PULL         8'h02
`define DIC_SUB_PIN_ALT          8'h03

// Subindices of the input conditioning control object.
`define DIC_SUB_IN_COUNT         8'h00
`define DIC_SUB_ROLE_EN          8'h01
`define DIC_SUB_POL_INV          8'h02
`define DIC_SUB_OVR_EN           8'h03
`define DIC_SUB_OVR_VAL          8'h04
`define DIC_SUB_RAW              8'h05
`define DIC_SUB_RANGE            8'h06
`define DIC_SUB_RECV             8'h07
`define DIC_SUB_REMAP            8'h08

// Reset values.
`define DIC_RST_PIN_COUNT        8'h03
`define DIC_RST_IN_COUNT         8'h08
`define DIC_RST_MASK16           16'h0000
`define DIC_RST_WORD32           32'h00000000

// Field positions in the role enable word.
`define DIC_ROLE_NEG_LIMIT       0
`define DIC_ROLE_POS_LIMIT       1
`define DIC_ROLE_HOME            2
`define DIC_ROLE_INTERLOCK       3

// Field positions in the alternate function mask.
`define DIC_ALT_STEP_CLOCK       1
`define DIC_ALT_STEP_DIR         2

// Field position of the routing switch.
`define DIC_REMAP_ON             0

`endif

// ===== logic/dic_input_conditioning.v
// Digital input conditioning: polarity, forcing, raw view, role enables,
// receiver selection, routing switch and multipurpose pin configuration.
// Assumes input pins are asynchronous and object accesses come from logic
// on sys_clk_i, one request per cycle at most.
`timescale 1ns/1ps
`include "dic_regs.vh"

module dic_input_conditioning #(
	parameter NUM_IN  = 8,          // Number of digital input pins.
	parameter NUM_PIN = 4           // Number of multipurpose pins.
) (
	// Clock and reset.
	input  wire                sys_clk_i,
	input  wire                reset_i,
	// Object dictionary access port.
	input  wire [15:0]         od_index_i,
	input  wire [7:0]          od_subindex_i,
	input  wire                od_wr_i,
	input  wire                od_rd_i,
	input  wire [31:0]         od_wdata_i,
	output reg  [31:0]         od_rdata_o,
	output reg                 od_ack_o,
	output reg                 od_err_o,
	// Input pins and routed image.
	input  wire [NUM_IN-1:0]   in_pin_i,
	input  wire [31:0]         routed_image_i,
	// Conditioned results.
	output reg  [31:0]         digital_input_image_o,
	output reg                 neg_limit_o,
	output reg                 pos_limit_o,
	output reg                 home_switch_o,
	output reg                 interlock_o,
	output reg                 pin2_step_clock_o,
	output reg                 pin3_step_direction_o,
	output reg                 step_inputs_on_o,
	// Receiver and range selection toward the input stages.
	output reg  [NUM_IN-1:0]   diff_receive_o,
	output reg  [NUM_IN-1:0]   range_select_o,
	// Multipurpose pin control.
	input  wire [NUM_PIN-1:0]  mp_out_data_i,
	output reg  [NUM_PIN-1:0]  mp_out_o,
	output reg  [NUM_PIN-1:0]  mp_out_en_o,
	output reg  [NUM_PIN-1:0]  mp_pull_up_o,
	output reg  [NUM_PIN-1:0]  mp_pull_en_o
);

	// Object storage.
	reg  [15:0]        pin_dir_mask_r;      // Multipurpose pin direction.
	reg  [15:0]        pin_pull_mask_r;     // Pull-up or pull-down choice.
	reg  [15:0]        pin_alt_mask_r;      // Alternate function choice.
	reg  [31:0]        role_enable_r;       // Special role enables.
	reg  [31:0]        pol_invert_r;        // Per-input polarity inversion.
	reg  [31:0]        ovr_enable_r;        // Per-input override enable.
	reg  [31:0]        ovr_value_r;         // Per-input override level.
	reg  [31:0]        range_choice_r;      // Input range selection.
	reg  [31:0]        recv_type_r;         // Receiver type selection.
	reg  [31:0]        remap_enable_r;      // Routing switch.

	// Pin synchroniser and sampled levels.
	reg  [NUM_IN-1:0]  sync1_r;             // First stage, read by sync2 only.
	reg  [NUM_IN-1:0]  sync2_r;             // Sampled pin levels.

	// Combinational results.
	reg  [31:0]        raw_word;            // Sampled levels widened.
	reg  [31:0]        inv_eff;             // Inversion after exemptions.
	reg  [31:0]        cond_word;           // Conditioned fixed-map image.
	reg  [31:0]        image_nxt;           // Image that goes out.
	reg  [31:0]        rdata_nxt;           // Read data for this access.
	reg                hit_nxt;             // Access addresses an entry.
	reg                ro_nxt;              // Entry is read only.
	wire [NUM_PIN-1:0] alt_pins;            // Alternate function per pin.

	// Width-safe extraction of the multipurpose pin field of a mask.
	function [NUM_PIN-1:0] pin_field;
		input [15:0] mask;
		begin
			pin_field = mask[NUM_PIN-1:0];
		end
	endfunction

	// Width-safe extraction of the input field of a 32-bit word.
	function [NUM_IN-1:0] in_field;
		input [31:0] word;
		begin
			in_field = word[NUM_IN-1:0];
		end
	endfunction

	// Pins claimed by a step input are never driven by this block.
	assign alt_pins = pin_field(pin_alt_mask_r);

	// Two flip-flop synchroniser for the asynchronous pins.
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			sync1_r <= {NUM_IN{1'b0}};
			sync2_r <= {NUM_IN{1'b0}};
		end else begin
			// Only the second stage is read, so a metastable first stage
			// has a full cycle to settle.
			sync1_r <= in_pin_i;
			sync2_r <= sync1_r;
		end
	end

	// Conditioning path from sampled level to the input image.
	always @* begin
		// Bits above the last pin read as zero in the raw view.
		raw_word = 32'h00000000;
		raw_word[NUM_IN-1:0] = sync2_r;
		// Inversion starts from the stored word, less the exempt bits.
		inv_eff = pol_invert_r;
		// Step inputs keep their electrical sense; a flipped clock would
		// move the counting edge and a flipped direction the motion.
		if (pin_alt_mask_r[`DIC_ALT_STEP_CLOCK]) begin
			inv_eff[`DIC_ALT_STEP_CLOCK] = 1'b0;
		end
		if (pin_alt_mask_r[`DIC_ALT_STEP_DIR]) begin
			inv_eff[`DIC_ALT_STEP_DIR] = 1'b0;
		end
		// Forced bits take the override value, others the corrected level.
		cond_word = (ovr_enable_r & ovr_value_r) |
			(~ovr_enable_r & (raw_word ^ inv_eff));
		// Routing replaces the fixed pin-to-bit map as a whole.
		if (remap_enable_r[`DIC_REMAP_ON]) begin
			image_nxt = routed_image_i;
		end else begin
			image_nxt = cond_word;
		end
	end

	// Registered outputs of the conditioning path.
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			// Every result idles low until the first edge after release.
			digital_input_image_o <= `DIC_RST_WORD32;
			neg_limit_o           <= 1'b0;
			pos_limit_o           <= 1'b0;
			home_switch_o         <= 1'b0;
			interlock_o           <= 1'b0;
			pin2_step_clock_o     <= 1'b0;
			pin3_step_direction_o <= 1'b0;
			step_inputs_on_o      <= 1'b0;
		end else begin
			// Registered so that all bits of the image move on one edge.
			digital_input_image_o <= image_nxt;
			// A role fires only when enabled; a role left on for an
			// unwired input would react to noise, so software must clear it.
			neg_limit_o <= role_enable_r[`DIC_ROLE_NEG_LIMIT] &
				cond_word[`DIC_ROLE_NEG_LIMIT];
			pos_limit_o <= role_enable_r[`DIC_ROLE_POS_LIMIT] &
				cond_word[`DIC_ROLE_POS_LIMIT];
			home_switch_o <= role_enable_r[`DIC_ROLE_HOME] &
				cond_word[`DIC_ROLE_HOME];
			interlock_o <= role_enable_r[`DIC_ROLE_INTERLOCK] &
				cond_word[`DIC_ROLE_INTERLOCK];
			// Step inputs pass the raw level, never inverted or forced.
			pin2_step_clock_o <= pin_alt_mask_r[`DIC_ALT_STEP_CLOCK] &
				raw_word[`DIC_ALT_STEP_CLOCK];
			pin3_step_direction_o <= pin_alt_mask_r[`DIC_ALT_STEP_DIR] &
				raw_word[`DIC_ALT_STEP_DIR];
			step_inputs_on_o <= pin_alt_mask_r[`DIC_ALT_STEP_CLOCK] &
				pin_alt_mask_r[`DIC_ALT_STEP_DIR];
		end
	end

	// Registered controls toward pins and input stages.
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			// Pulls read as off in reset and turn on at the first edge after.
			diff_receive_o <= {NUM_IN{1'b0}};
			range_select_o <= {NUM_IN{1'b0}};
			mp_out_o       <= {NUM_PIN{1'b0}};
			mp_out_en_o    <= {NUM_PIN{1'b0}};
			mp_pull_up_o   <= {NUM_PIN{1'b0}};
			mp_pull_en_o   <= {NUM_PIN{1'b0}};
		end else begin
			// Stages without a differential receiver ignore their bit.
			diff_receive_o <= in_field(recv_type_r);
			// Range bits pass through; the input stages give them meaning.
			range_select_o <= in_field(range_choice_r);
			// Masked so that an input pin never carries stale output data.
			mp_out_o <= mp_out_data_i & pin_field(pin_dir_mask_r);
			// A pin taken for a step input is never driven.
			mp_out_en_o <= pin_field(pin_dir_mask_r) & ~alt_pins;
			mp_pull_up_o <= pin_field(pin_pull_mask_r);
			// The pull only acts while the pin is an input.
			mp_pull_en_o <= ~(pin_field(pin_dir_mask_r) & ~alt_pins);
		end
	end

	// Read data and address decode for the object port.
	always @* begin
		// Start from a hit with zero data; unmapped branches clear the hit.
		rdata_nxt = 32'h00000000;
		hit_nxt   = 1'b1;
		ro_nxt    = 1'b0;
		if (od_index_i == `DIC_IDX_PIN_SETUP) begin
			// Pin setup: three 16-bit masks and a fixed entry count.
			case (od_subindex_i)
				`DIC_SUB_PIN_COUNT: begin
					// The count is a constant, so a write to it is refused.
					rdata_nxt[7:0] = `DIC_RST_PIN_COUNT;
					ro_nxt = 1'b1;
				end
				`DIC_SUB_PIN_DIR:  rdata_nxt[15:0] = pin_dir_mask_r;
				`DIC_SUB_PIN_PULL: rdata_nxt[15:0] = pin_pull_mask_r;
				`DIC_SUB_PIN_ALT:  rdata_nxt[15:0] = pin_alt_mask_r;
				default:           hit_nxt = 1'b0;
			endcase
		end else if (od_index_i == `DIC_IDX_INPUT_CTRL) begin
			// Input control: eight 32-bit words and a fixed entry count.
			case (od_subindex_i)
				`DIC_SUB_IN_COUNT: begin
					// The count is a constant, so a write to it is refused.
					rdata_nxt[7:0] = `DIC_RST_IN_COUNT;
					ro_nxt = 1'b1;
				end
				`DIC_SUB_ROLE_EN: rdata_nxt = role_enable_r;
				`DIC_SUB_POL_INV: rdata_nxt = pol_invert_r;
				`DIC_SUB_OVR_EN:  rdata_nxt = ovr_enable_r;
				`DIC_SUB_OVR_VAL: rdata_nxt = ovr_value_r;
				// The raw entry reflects the pins; writes are accepted and
				// dropped so the view can never be falsified.
				`DIC_SUB_RAW:     rdata_nxt = raw_word;
				`DIC_SUB_RANGE:   rdata_nxt = range_choice_r;
				`DIC_SUB_RECV:    rdata_nxt = recv_type_r;
				`DIC_SUB_REMAP:   rdata_nxt = remap_enable_r;
				default:          hit_nxt = 1'b0;
			endcase
		end else begin
			// Any other index belongs elsewhere and answers with an error.
			hit_nxt = 1'b0;
		end
	end

	// Object writes and the one-cycle answer.
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			// Every stored entry returns to zero with the reset.
			pin_dir_mask_r  <= `DIC_RST_MASK16;
			pin_pull_mask_r <= `DIC_RST_MASK16;
			pin_alt_mask_r  <= `DIC_RST_MASK16;
			role_enable_r   <= `DIC_RST_WORD32;
			pol_invert_r    <= `DIC_RST_WORD32;
			ovr_enable_r    <= `DIC_RST_WORD32;
			ovr_value_r     <= `DIC_RST_WORD32;
			range_choice_r  <= `DIC_RST_WORD32;
			recv_type_r     <= `DIC_RST_WORD32;
			remap_enable_r  <= `DIC_RST_WORD32;
			od_rdata_o      <= `DIC_RST_WORD32;
			od_ack_o        <= 1'b0;
			od_err_o        <= 1'b0;
		end else begin
			// Exactly one of ack and err answers a request, one cycle on.
			od_ack_o   <= (od_wr_i | od_rd_i) & hit_nxt & ~(od_wr_i & ro_nxt);
			od_err_o   <= (od_wr_i | od_rd_i) & (~hit_nxt | (od_wr_i & ro_nxt));
			// Read data stands for the answer cycle only and is zero
			// otherwise, so a stale word is never taken for an answer.
			od_rdata_o <= (od_rd_i & hit_nxt) ? rdata_nxt : `DIC_RST_WORD32;
			// Upper halves of a 16-bit mask write are dropped.
			if (od_wr_i && hit_nxt && (od_index_i == `DIC_IDX_PIN_SETUP)) begin
				case (od_subindex_i)
					`DIC_SUB_PIN_DIR:  pin_dir_mask_r  <= od_wdata_i[15:0];
					`DIC_SUB_PIN_PULL: pin_pull_mask_r <= od_wdata_i[15:0];
					`DIC_SUB_PIN_ALT:  pin_alt_mask_r  <= od_wdata_i[15:0];
					default: begin
						// Counts and unmapped items store nothing.
					end
				endcase
			end
			// The raw entry has no item here, so a write to it is dropped.
			if (od_wr_i && hit_nxt && (od_index_i == `DIC_IDX_INPUT_CTRL)) begin
				case (od_subindex_i)
					// Upper bits of the role, range, receiver and routing words are stored but drive nothing.
					`DIC_SUB_ROLE_EN: role_enable_r <= od_wdata_i;
					`DIC_SUB_POL_INV: pol_invert_r  <= od_wdata_i;
					`DIC_SUB_OVR_EN:  ovr_enable_r  <= od_wdata_i;
					`DIC_SUB_OVR_VAL: ovr_value_r   <= od_wdata_i;
					`DIC_SUB_RANGE:   range_choice_r <= od_wdata_i;
					`DIC_SUB_RECV:    recv_type_r   <= od_wdata_i;
					`DIC_SUB_REMAP:   remap_enable_r <= od_wdata_i;
					default: begin
						// Counts and the raw entry store nothing.
					end
				endcase
			end
		end
	end

endmodule // dic_input_conditioning

// ===== test/dic_switch_model.sv
// Model of the switches and sensors wired to the digital input pins.
// Assumes the bench sets the wanted levels at rising clock edges.
`timescale 1ns/1ps
module dic_switch_model (
	// Levels the switches should settle to.
	input  wire [7:0] level_i,
	// Pin levels seen by the block.
	output reg  [7:0] pin_o
);
	// Contacts settle late, so pins never move on a clock edge.
	initial pin_o = 8'h00;
	always @(level_i) pin_o <= #7 level_i;
endmodule // dic_switch_model

// ===== test/dic_checker_sva.sv
// Concurrent checks on the ports of the input conditioning block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module dic_checker_sva #(
	parameter NUM_IN  = 8,
	parameter NUM_PIN = 4
) (
	input wire               sys_clk_i,
	input wire               reset_i,
	input wire [15:0]        od_index_i,
	input wire [7:0]         od_subindex_i,
	input wire               od_wr_i,
	input wire               od_rd_i,
	input wire [31:0]        od_wdata_i,
	input wire [31:0]        od_rdata_o,
	input wire               od_ack_o,
	input wire               od_err_o,
	input wire [NUM_IN-1:0]  in_pin_i,
	input wire               pin2_step_clock_o,
	input wire               step_inputs_on_o,
	input wire [NUM_IN-1:0]  diff_receive_o,
	input wire [NUM_PIN-1:0] mp_out_data_i,
	input wire [NUM_PIN-1:0] mp_out_o,
	input wire [NUM_PIN-1:0] mp_out_en_o,
	input wire [NUM_PIN-1:0] mp_pull_en_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// A receiver write is taken, then lands two edges later.
	sequence s_recv_wr;
		od_wr_i && od_index_i == 16'h3240 && od_subindex_i == 8'h07;
	endsequence
	a_req_answer: assert property (
		(od_wr_i || od_rd_i) |=> (od_ack_o != od_err_o))
		else $error("request not answered by one pulse");
	a_no_spurious: assert property (
		!(od_wr_i || od_rd_i) |=> !od_ack_o && !od_err_o)
		else $error("answer without request");
	a_rdata_idle: assert property (!od_rd_i |=> od_rdata_o == 32'h0)
		else $error("read data not cleared");
	a_pull_inputs: assert property (
		!$past(reset_i) |-> mp_pull_en_o == ~mp_out_en_o)
		else $error("pull active on a driven pin");
	a_out_gated: assert property (
		(mp_out_o & ~$past(mp_out_data_i)) == {NUM_PIN{1'b0}})
		else $error("pin driven high without data");
	a_step_raw: assert property (
		pin2_step_clock_o |-> $past(in_pin_i[1], 3))
		else $error("step clock not the raw pin level");
	a_alt_spares: assert property (
		step_inputs_on_o |-> mp_out_en_o[2:1] == 2'b00)
		else $error("step input pin driven");
	a_recv_write: assert property (
		s_recv_wr |-> ##2 diff_receive_o == $past(od_wdata_i[NUM_IN-1:0], 2))
		else $error("receiver select not updated");
endmodule // dic_checker_sva
bind dic_input_conditioning dic_checker_sva #(
	.NUM_IN(NUM_IN), .NUM_PIN(NUM_PIN)) CHK (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i),
	.od_index_i(od_index_i), .od_subindex_i(od_subindex_i),
	.od_wr_i(od_wr_i), .od_rd_i(od_rd_i), .od_wdata_i(od_wdata_i),
	.od_rdata_o(od_rdata_o), .od_ack_o(od_ack_o), .od_err_o(od_err_o),
	.in_pin_i(in_pin_i), .pin2_step_clock_o(pin2_step_clock_o),
	.step_inputs_on_o(step_inputs_on_o), .diff_receive_o(diff_receive_o),
	.mp_out_data_i(mp_out_data_i), .mp_out_o(mp_out_o),
	.mp_out_en_o(mp_out_en_o), .mp_pull_en_o(mp_pull_en_o));

// ===== test/dic_input_conditioning_bench.sv
// Self-checking bench for the input conditioning block.
// Assumes the switch model and the bound checker are compiled first.
`timescale 1ns/1ps
module dic_input_conditioning_bench;
	reg         sys_clk_i = 1'b0;
	reg         reset_i = 1'b1;
	reg  [15:0] od_index_i = 16'h0;
	reg  [7:0]  od_subindex_i = 8'h0;
	reg         od_wr_i = 1'b0;
	reg         od_rd_i = 1'b0;
	reg  [31:0] od_wdata_i = 32'h0;
	reg  [31:0] routed_image_i = 32'h0;
	reg  [3:0]  mp_out_data_i = 4'h0;
	reg  [7:0]  sw_level = 8'h0;
	wire [7:0]  in_pin_i, dr, rs;
	wire [31:0] od_rdata_o, img;
	wire        od_ack_o, od_err_o, nl, pl, hs, il, sc, sd, so;
	wire [3:0]  mo, me, mu, mn;
	integer     num_errors = 0, cmp_count = 0, seed = 85526, i, cyc = 0;
	reg  [32:0] exp_q[$];
	reg  [31:0] inv, oen, ov, role, e;
	initial forever #25 sys_clk_i = ~sys_clk_i;
	dic_switch_model SW (.level_i(sw_level), .pin_o(in_pin_i));
	dic_input_conditioning DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.od_index_i(od_index_i), .od_subindex_i(od_subindex_i),
		.od_wr_i(od_wr_i), .od_rd_i(od_rd_i), .od_wdata_i(od_wdata_i),
		.od_rdata_o(od_rdata_o), .od_ack_o(od_ack_o), .od_err_o(od_err_o),
		.in_pin_i(in_pin_i), .routed_image_i(routed_image_i),
		.digital_input_image_o(img), .neg_limit_o(nl), .pos_limit_o(pl),
		.home_switch_o(hs), .interlock_o(il), .pin2_step_clock_o(sc),
		.pin3_step_direction_o(sd), .step_inputs_on_o(so),
		.diff_receive_o(dr), .range_select_o(rs),
		.mp_out_data_i(mp_out_data_i), .mp_out_o(mo), .mp_out_en_o(me),
		.mp_pull_up_o(mu), .mp_pull_en_o(mn));
	task wrap_up;
		begin
			if (exp_q.size() != 0) num_errors = num_errors + 1;
			$display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [32:0] got, input [32:0] ex);
		begin
			cmp_count = cmp_count + 1;
			if (got !== ex) begin
				num_errors = num_errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, ex);
			end
		end
	endtask
	// One access pulse; the expected answer is noted for the monitor.
	task acc(input w, input [15:0] x, input [7:0] s, input [31:0] d,
		input [32:0] ex);
		begin
			@(posedge sys_clk_i);
			od_wr_i <= w;
			od_rd_i <= !w;
			od_index_i <= x;
			od_subindex_i <= s;
			od_wdata_i <= d;
			exp_q.push_back(ex);
			@(posedge sys_clk_i);
			od_wr_i <= 1'b0;
			od_rd_i <= 1'b0;
		end
	endtask
	task wr(input [15:0] x, input [7:0] s, input [31:0] d);
		acc(1'b1, x, s, d, 33'h0);
	endtask
	task rd(input [15:0] x, input [7:0] s, input [31:0] ex);
		acc(1'b0, x, s, 32'h0, {1'b0, ex});
	endtask
	// Registered outputs settle two edges after a write; wait past that.
	task settle;
		begin
			repeat (3) @(posedge sys_clk_i);
			@(negedge sys_clk_i);
		end
	endtask
	// Every answer is compared with the oldest note; a hang is cut short.
	// Answers are looked at mid-cycle, where they stand settled, and not
	// in reset, where the outputs are unknown before the first edge.
	always @(negedge sys_clk_i) begin
		cyc = cyc + 1;
		if (!reset_i && (od_ack_o !== 1'b0 || od_err_o !== 1'b0)) begin
			if (exp_q.size() == 0) chk({od_err_o, od_rdata_o}, 33'h0);
			else chk({od_err_o, od_rdata_o}, exp_q.pop_front());
		end
		if (cyc == 6000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(16'h3231, 8'h00, 32'h3);
		rd(16'h3240, 8'h00, 32'h8);
		for (i = 1; i < 9; i = i + 1) rd(16'h3240, i[7:0], 32'h0);
		for (i = 1; i < 4; i = i + 1) rd(16'h3231, i[7:0], 32'h0);
		acc(1'b1, 16'h3240, 8'h00, 32'h5, 33'h100000000);
		acc(1'b0, 16'h3240, 8'h09, 32'h0, 33'h100000000);
		acc(1'b0, 16'h3232, 8'h01, 32'h0, 33'h100000000);
		$display("Test reset values done");
		for (i = 1; i < 9; i = i + 1) if (i != 5) begin
			e = $random(seed);
			wr(16'h3240, i[7:0], e);
			rd(16'h3240, i[7:0], e);
		end
		for (i = 1; i < 4; i = i + 1) begin
			e = $random(seed);
			wr(16'h3231, i[7:0], e);
			rd(16'h3231, i[7:0], {16'h0, e[15:0]});
		end
		wr(16'h3240, 8'h05, 32'hffffffff);
		rd(16'h3240, 8'h05, 32'h0);
		$display("Test readback done");
		wr(16'h3231, 8'h03, 32'h0);
		wr(16'h3240, 8'h08, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			inv = $random(seed);
			oen = $random(seed);
			ov = $random(seed);
			role = $random(seed);
			sw_level <= $random(seed);
			wr(16'h3240, 8'h02, inv);
			wr(16'h3240, 8'h03, oen);
			wr(16'h3240, 8'h04, ov);
			wr(16'h3240, 8'h01, role);
			settle;
			e = (oen & ov) | (~oen & ({24'h0, sw_level} ^ inv));
			chk(img, e);
			chk({il, hs, pl, nl}, role[3:0] & e[3:0]);
			rd(16'h3240, 8'h05, {24'h0, sw_level});
		end
		$display("Test conditioning done");
		routed_image_i <= $random(seed);
		wr(16'h3240, 8'h08, 32'h1);
		settle;
		chk(img, routed_image_i);
		wr(16'h3240, 8'h08, 32'h2);
		settle;
		chk(img, e);
		$display("Test routing done");
		@(posedge sys_clk_i);
		mp_out_data_i <= $random(seed);
		sw_level <= 8'h06;
		wr(16'h3240, 8'h02, 32'h6);
		wr(16'h3231, 8'h01, 32'h6);
		wr(16'h3231, 8'h02, 32'h9);
		wr(16'h3231, 8'h03, 32'h2);
		settle;
		chk({me, mo}, {4'h4, mp_out_data_i & 4'h6});
		chk({mu, mn}, {4'h9, 4'hb});
		chk({sc, sd, so}, 3'b100);
		wr(16'h3231, 8'h03, 32'h6);
		settle;
		chk({sc, sd, so, me}, {3'b111, 4'h0});
		// Bits 1 and 2 now ignore the stored inversion of 6.
		e = (oen & ov) | (~oen & 32'h6);
		chk(img, e);
		// Input 4 has no interlock wired, so software clears its role.
		wr(16'h3240, 8'h01, 32'h7);
		settle;
		chk({il, hs, pl, nl}, {1'b0, e[2:0]});
		e = $random(seed);
		wr(16'h3240, 8'h07, e);
		wr(16'h3240, 8'h06, {e[15:0], e[31:16]});
		settle;
		chk(dr, e[7:0]);
		chk(rs, e[23:16]);
		$display("Test pin setup done");
		// A reset in mid-run must clear the entries; after it the pulls are on and the image follows the pins.
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(16'h3231, 8'h03, 32'h0);
		rd(16'h3240, 8'h02, 32'h0);
		settle;
		chk({sc, sd, so, me, mn}, {3'b000, 4'h0, 4'hf});
		chk({il, hs, pl, nl, dr, rs}, 20'h0);
		chk(img, 32'h6);
		$display("Test mid-run reset done");
		wrap_up;
	end
endmodule // dic_input_conditioning_bench
